// >>> rtl/odsc_output_divider_sync_control.v
// Output mode, polarity and channel divider sync control for the second loop.
// Assumes i_clk is the divided VCO clock domain; i_vco_en marks each divider
// input edge. Register port is the write/read side of an external serial core.
// i_lock and i_cal_done come from analogue logic and are resynchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "odsc_map.vh"

module odsc_output_divider_sync_control #(
  parameter NUM_OUT = `ODSC_NUM_OUT,
  parameter NUM_GRP = `ODSC_NUM_GRP,
  parameter DIV_W = 8
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_vco_en,
  input wire i_lock,
  input wire i_cal_done,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  output wire o_cal_request,
  output wire o_div_hold,
  output reg [NUM_OUT-1:0] o_out_pos_pin,
  output reg [NUM_OUT-1:0] o_out_neg_pin,
  output reg [NUM_OUT-1:0] o_out_pos_en,
  output reg [NUM_OUT-1:0] o_out_neg_en,
  output reg [NUM_OUT-1:0] o_out_hstl,
  output wire [NUM_GRP-1:0] o_div_power
);

  // Group index of an output
  function [1:0] grp_of;
    input integer idx;
    begin
      if (idx < `ODSC_GRP1_FIRST)
        grp_of = 2'h0;
      else if (idx < `ODSC_GRP2_FIRST)
        grp_of = 2'h1;
      else if (idx < `ODSC_GRP3_FIRST)
        grp_of = 2'h2;
      else
        grp_of = 2'h3;
    end
  endfunction

  // Staged (written) and active (updated) copies
  reg [7:0] ctrl_stg_reg;
  reg [7:0] ctrl_act_reg;
  reg [4:0] out_stg_reg [0:NUM_OUT-1];
  reg [4:0] out_act_reg [0:NUM_OUT-1];
  reg [DIV_W-1:0] div_stg_reg [0:NUM_GRP-1];
  reg [DIV_W-1:0] div_act_reg [0:NUM_GRP-1];
  reg lock_meta_reg;
  reg lock_reg;
  reg cal_meta_reg;
  reg cal_reg;
  reg hold_reg;
  reg pend_reg;
  reg sync_dly_reg;
  reg [DIV_W-1:0] cnt_reg [0:NUM_GRP-1];
  reg [NUM_GRP-1:0] dclk_reg;
  reg [NUM_GRP-1:0] grp_on;
  wire upd;
  wire ready;
  wire act_sync;
  wire hold_next;

  // Update strobe is write-only and self-clearing
  assign upd = i_reg_wr && (i_reg_addr == `ODSC_UPDATE_ADDR)
    && i_reg_wdata[`ODSC_UPDATE_BIT];
  assign act_sync = ctrl_act_reg[`ODSC_SYNC_BIT];
  assign o_cal_request = ctrl_act_reg[`ODSC_CAL_BIT];
  assign ready = lock_reg & cal_reg;

  // Register writes land in staging only
  always @(posedge i_clk or negedge i_nrst)
  begin : stage_wr
    integer i;
    if (!i_nrst)
    begin
      ctrl_stg_reg <= `ODSC_CTRL_RST;
      for (i = 0; i < NUM_OUT; i = i + 1)
        out_stg_reg[i] <= `ODSC_OUT_RST;
      for (i = 0; i < NUM_GRP; i = i + 1)
        div_stg_reg[i] <= `ODSC_DIV_RST;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == `ODSC_CTRL_ADDR)
        ctrl_stg_reg <= i_reg_wdata;
      for (i = 0; i < NUM_OUT; i = i + 1)
        if (i_reg_addr == `ODSC_OUT_BASE + i[15:0])
          out_stg_reg[i] <= i_reg_wdata[4:0];
      for (i = 0; i < NUM_GRP; i = i + 1)
        if (i_reg_addr == `ODSC_DIV_BASE + i[15:0])
          div_stg_reg[i] <= i_reg_wdata[DIV_W-1:0];
    end
  end

  // Staged settings take effect only on the update strobe, so one
  // update gives at most one edge of the sync pulse
  always @(posedge i_clk or negedge i_nrst)
  begin : active_load
    integer i;
    if (!i_nrst)
    begin
      ctrl_act_reg <= `ODSC_CTRL_RST;
      for (i = 0; i < NUM_OUT; i = i + 1)
        out_act_reg[i] <= `ODSC_OUT_RST;
      for (i = 0; i < NUM_GRP; i = i + 1)
        div_act_reg[i] <= `ODSC_DIV_RST;
    end
    else if (upd)
    begin
      ctrl_act_reg <= ctrl_stg_reg;
      for (i = 0; i < NUM_OUT; i = i + 1)
        out_act_reg[i] <= out_stg_reg[i];
      for (i = 0; i < NUM_GRP; i = i + 1)
        div_act_reg[i] <= div_stg_reg[i];
    end
  end

  // Lock and calibration flags are analogue-side levels
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      lock_meta_reg <= 1'b0;
      lock_reg <= 1'b0;
      cal_meta_reg <= 1'b0;
      cal_reg <= 1'b0;
    end
    else
    begin
      lock_meta_reg <= i_lock;
      lock_reg <= lock_meta_reg;
      cal_meta_reg <= i_cal_done;
      cal_reg <= cal_meta_reg;
    end
  end

  // Hold while sync is high; after the fall keep holding until the loop
  // is locked and calibrated, so an early pulse is not lost
  assign hold_next = act_sync | (hold_reg & ~ready);

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      hold_reg <= 1'b0;
      pend_reg <= 1'b0;
      sync_dly_reg <= 1'b0;
    end
    else
    begin
      hold_reg <= hold_next;
      sync_dly_reg <= act_sync;
      // Falling edge seen but release still waits on lock and calibration
      if (sync_dly_reg & ~act_sync & ~ready)
        pend_reg <= 1'b1;
      else if (ready | act_sync)
        pend_reg <= 1'b0;
    end
  end

  assign o_div_hold = hold_reg;

  // A group divider runs while any of its outputs has a mode code other than off
  always @*
  begin : group_power
    integer i;
    i = 0;
    grp_on = {NUM_GRP{1'b0}};
    for (i = 0; i < NUM_OUT; i = i + 1)
      if (out_act_reg[i][2:0] != `ODSC_MODE_OFF)
        grp_on[grp_of(i)] = 1'b1;
  end

  assign o_div_power = grp_on;

  // Channel dividers; held counters sit at zero with output low, so the
  // restart state is fixed without needing any input clock edge.
  // Limitation: odd ratios give a one-input-cycle duty skew, since only
  // rising edges of the divider clock exist in this domain.
  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g = g + 1)
    begin : gen_div
      wire [DIV_W:0] half;
      wire [DIV_W-1:0] cnt_next;
      assign half = ({1'b0, div_act_reg[g]} + {{DIV_W{1'b0}}, 1'b1}) >> 1;
      assign cnt_next = (cnt_reg[g] == div_act_reg[g]) ? {DIV_W{1'b0}}
        : cnt_reg[g] + {{(DIV_W-1){1'b0}}, 1'b1};
      always @(posedge i_clk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          cnt_reg[g] <= {DIV_W{1'b0}};
          dclk_reg[g] <= 1'b0;
        end
        else if (hold_reg || !grp_on[g])
        begin
          cnt_reg[g] <= {DIV_W{1'b0}};
          dclk_reg[g] <= 1'b0;
        end
        else if (i_vco_en)
        begin
          cnt_reg[g] <= cnt_next;
          if (div_act_reg[g] == {DIV_W{1'b0}})
            dclk_reg[g] <= ~dclk_reg[g];
          else
            dclk_reg[g] <= ({1'b0, cnt_next} < half);
        end
      end
    end
  endgenerate

  // Pin drive per output from its group clock, mode and polarity
  always @(posedge i_clk or negedge i_nrst)
  begin : pin_drive
    integer i;
    if (!i_nrst)
    begin
      o_out_pos_pin <= {NUM_OUT{1'b0}};
      o_out_neg_pin <= {NUM_OUT{1'b0}};
      o_out_pos_en <= {NUM_OUT{1'b0}};
      o_out_neg_en <= {NUM_OUT{1'b0}};
      o_out_hstl <= {NUM_OUT{1'b0}};
    end
    else
    begin
      for (i = 0; i < NUM_OUT; i = i + 1)
      begin
        // Differential default; CMOS modes override below
        o_out_pos_pin[i] <= dclk_reg[grp_of(i)];
        o_out_neg_pin[i] <= ~dclk_reg[grp_of(i)];
        o_out_pos_en[i] <= 1'b0;
        o_out_neg_en[i] <= 1'b0;
        o_out_hstl[i] <= 1'b0;
        case (out_act_reg[i][2:0])
          `ODSC_MODE_HSTL:
          begin
            o_out_pos_en[i] <= 1'b1;
            o_out_neg_en[i] <= 1'b1;
            o_out_hstl[i] <= 1'b1;
          end
          `ODSC_MODE_CMOS_BOTH, `ODSC_MODE_CMOS_POS, `ODSC_MODE_CMOS_NEG:
          begin
            // Bit 4 inverts P; bit 3 clear inverts N
            o_out_pos_pin[i] <= dclk_reg[grp_of(i)]
              ^ out_act_reg[i][`ODSC_POL_LSB+1];
            o_out_neg_pin[i] <= dclk_reg[grp_of(i)]
              ^ ~out_act_reg[i][`ODSC_POL_LSB];
            o_out_pos_en[i] <= (out_act_reg[i][2:0] != `ODSC_MODE_CMOS_NEG);
            o_out_neg_en[i] <= (out_act_reg[i][2:0] != `ODSC_MODE_CMOS_POS);
          end
          // Off and the undefined codes leave the driver disabled
          default:
          begin
            o_out_pos_en[i] <= 1'b0;
            o_out_neg_en[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // Read data: staged settings, live status
  always @(posedge i_clk or negedge i_nrst)
  begin : read_back
    integer i;
    if (!i_nrst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      o_reg_rdata <= 8'h00;
      if (i_reg_addr == `ODSC_CTRL_ADDR)
        o_reg_rdata <= ctrl_stg_reg;
      if (i_reg_addr == `ODSC_STATUS_ADDR)
        o_reg_rdata <= {4'h0, pend_reg, hold_reg, cal_reg, lock_reg};
      for (i = 0; i < NUM_OUT; i = i + 1)
        if (i_reg_addr == `ODSC_OUT_BASE + i[15:0])
          o_reg_rdata <= {3'h0, out_stg_reg[i]};
      for (i = 0; i < NUM_GRP; i = i + 1)
        if (i_reg_addr == `ODSC_DIV_BASE + i[15:0])
          o_reg_rdata <= div_stg_reg[i];
    end
  end

endmodule
`default_nettype wire

// >>> shared/odsc_map.vh
// Address map, field positions and codes for the output divider sync control.
// Included by the design; definitions only.
`ifndef ODSC_MAP_VH
`define ODSC_MAP_VH
// Register offsets (16-bit register address)
`define ODSC_UPDATE_ADDR 16'h0005
`define ODSC_CTRL_ADDR 16'h0200
`define ODSC_STATUS_ADDR 16'h0201
`define ODSC_OUT_BASE 16'h0210
`define ODSC_DIV_BASE 16'h0220
// Field positions
`define ODSC_UPDATE_BIT 0
`define ODSC_CAL_BIT 1
`define ODSC_SYNC_BIT 2
`define ODSC_MODE_LSB 0
`define ODSC_POL_LSB 3
// Reset values
`define ODSC_CTRL_RST 8'h00
`define ODSC_OUT_RST 5'h00
`define ODSC_DIV_RST 8'h00
// Driver mode codes
`define ODSC_MODE_OFF 3'h0
`define ODSC_MODE_HSTL 3'h1
`define ODSC_MODE_CMOS_BOTH 3'h4
`define ODSC_MODE_CMOS_POS 3'h5
`define ODSC_MODE_CMOS_NEG 3'h6
// Counts
`define ODSC_NUM_OUT 12
`define ODSC_NUM_GRP 4
// First output index of groups two, three and four
`define ODSC_GRP1_FIRST 2
`define ODSC_GRP2_FIRST 5
`define ODSC_GRP3_FIRST 8
`endif

// >>> verification/odsc_board_load.sv
// Board loads on the twelve output pin pairs.
// Assumes pull-down terminations, so an undriven pin reads low.
`timescale 1ns/1ps
`default_nettype none
module odsc_board_load (
  input wire logic [11:0] i_pos,
  input wire logic [11:0] i_pos_en,
  input wire logic [11:0] i_neg,
  input wire logic [11:0] i_neg_en,
  output logic [11:0] o_line_pos,
  output logic [11:0] o_line_neg
);
  // Released pins fall to the termination level
  assign o_line_pos = i_pos & i_pos_en;
  assign o_line_neg = i_neg & i_neg_en;
endmodule
`default_nettype wire

// >>> verification/odsc_assertions.sv
// Port checks for the output divider sync control.
// Assumes one clock domain and the map header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "odsc_map.vh"
module odsc_checker #(
  parameter NUM_OUT = 12
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_lock,
  input wire logic i_cal_done,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_div_hold,
  input wire logic [NUM_OUT-1:0] o_out_pos_pin,
  input wire logic [NUM_OUT-1:0] o_out_pos_en,
  input wire logic [NUM_OUT-1:0] o_out_neg_en,
  input wire logic [NUM_OUT-1:0] o_out_hstl,
  input wire logic [3:0] o_div_power
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Register writes that make up a manual sync
  sequence s_upd;
    i_reg_wr && i_reg_addr == `ODSC_UPDATE_ADDR && i_reg_wdata[0];
  endsequence
  sequence s_set;
    i_reg_wr && i_reg_addr == `ODSC_CTRL_ADDR && i_reg_wdata[2];
  endsequence
  sequence s_clr;
    i_reg_wr && i_reg_addr == `ODSC_CTRL_ADDR && !i_reg_wdata[2];
  endsequence
  a_sync_hold_rise: assert property (s_set ##1 s_upd |-> ##[1:3] o_div_hold)
    else $error("hold missing after sync set");
  a_sync_hold_fall: assert property (s_clr ##1 s_upd ##0 (i_lock && i_cal_done)
    |-> ##[1:6] !o_div_hold) else $error("hold stuck after sync clear");
  a_release_gated: assert property ($fell(o_div_hold) |-> i_lock && i_cal_done)
    else $error("hold fell without lock and cal");
  a_pending_hold: assert property (o_div_hold && !i_lock && !$past(i_lock)
    && !$past(i_lock, 2) |=> o_div_hold) else $error("pending sync released early");
  a_pins_frozen: assert property (o_div_hold [*4] |-> $stable(o_out_pos_pin))
    else $error("pins moved during hold");
  a_rdata_stands: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
    else $error("read data changed without read");
  // Lag of one cycle: enables are registered, power is not
  a_grp_first_off: assert property (!o_div_power[0] && !$past(o_div_power[0])
    |-> ~|{o_out_pos_en[1:0], o_out_neg_en[1:0], o_out_hstl[1:0]}) else $error("group 0");
  a_grp_last_off: assert property (!o_div_power[3] && !$past(o_div_power[3])
    |-> ~|{o_out_pos_en[11:8], o_out_neg_en[11:8], o_out_hstl[11:8]}) else $error("group 3");
endmodule
bind odsc_output_divider_sync_control odsc_checker #(.NUM_OUT(NUM_OUT)) odsc_checker_inst (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_lock(i_lock), .i_cal_done(i_cal_done),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_div_hold(o_div_hold),
  .o_out_pos_pin(o_out_pos_pin), .o_out_pos_en(o_out_pos_en), .o_out_neg_en(o_out_neg_en),
  .o_out_hstl(o_out_hstl), .o_div_power(o_div_power));
`default_nettype wire

// >>> verification/test_output_divider_sync_control.sv
// Self-checking bench for the output divider sync control.
// Assumes the map header on the include path; the VCO enable runs every cycle.
`timescale 1ns/1ps
`default_nettype none
`include "odsc_map.vh"
module test_output_divider_sync_control;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_vco_en = 1'b1, i_lock = 1'b0, i_cal_done = 1'b0;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, o_cal_request, o_div_hold;
  logic [15:0] i_reg_addr = 16'h0000;
  logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
  logic [11:0] o_out_pos_pin, o_out_neg_pin, o_out_pos_en, o_out_neg_en, o_out_hstl, lp, ln, last;
  logic [3:0] o_div_power;
  int fails = 0, cmp_count = 0, cyc = 0, edges;
  always #5 i_clk = ~i_clk;
  odsc_output_divider_sync_control odsc_output_divider_sync_control_inst (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_vco_en(i_vco_en), .i_lock(i_lock), .i_cal_done(i_cal_done),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_cal_request(o_cal_request),
    .o_div_hold(o_div_hold), .o_out_pos_pin(o_out_pos_pin), .o_out_neg_pin(o_out_neg_pin),
    .o_out_pos_en(o_out_pos_en), .o_out_neg_en(o_out_neg_en), .o_out_hstl(o_out_hstl),
    .o_div_power(o_div_power));
  odsc_board_load odsc_board_load_inst (.i_pos(o_out_pos_pin), .i_pos_en(o_out_pos_en),
    .i_neg(o_out_neg_pin), .i_neg_en(o_out_neg_en), .o_line_pos(lp), .o_line_neg(ln));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One write per edge, so back-to-back writes keep the strobe up
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
  endtask
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
    end
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    idle(1);
    chk("rdata", {8'h00, o_reg_rdata}, {8'h00, exp});
  endtask
  task automatic sync_pulse();
    wr(`ODSC_CTRL_ADDR, 8'h04);
    wr(`ODSC_UPDATE_ADDR, 8'h01);
    idle(4);
    wr(`ODSC_CTRL_ADDR, 8'h00);
    wr(`ODSC_UPDATE_ADDR, 8'h01);
    idle(1);
  endtask
  task automatic tally_and_finish();
    $display("[test] checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Cycle ceiling well above the whole sequence
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(`ODSC_CTRL_ADDR, 8'h00);
    rd(`ODSC_UPDATE_ADDR, 8'h00);
    rd(16'h0300, 8'h00);
    chk("power", {12'h000, o_div_power}, 16'h0000);
    $display("[test] reset done");
    // Modes stay staged until the update strobe
    wr(`ODSC_OUT_BASE, {5'h00, `ODSC_MODE_HSTL});
    wr(`ODSC_OUT_BASE + 16'h0002, 8'h0C);
    wr(`ODSC_OUT_BASE + 16'h0003, 8'h0C);
    wr(`ODSC_OUT_BASE + 16'h0005, {5'h00, `ODSC_MODE_CMOS_POS});
    wr(`ODSC_OUT_BASE + 16'h0008, {5'h00, `ODSC_MODE_CMOS_NEG});
    wr(`ODSC_CTRL_ADDR, 8'h02);
    idle(2);
    chk("staged", {4'h0, o_out_pos_en}, 16'h0000);
    chk("cal_stg", {15'h0, o_cal_request}, 16'h0000);
    wr(`ODSC_UPDATE_ADDR, 8'h01);
    idle(3);
    chk("cal_req", {15'h0, o_cal_request}, 16'h0001);
    chk("hstl", {4'h0, o_out_hstl}, 16'h0001);
    chk("pos_en", {4'h0, o_out_pos_en & 12'hFFE}, 16'h002C);
    chk("neg_en", {4'h0, o_out_neg_en & 12'hFFE}, 16'h010C);
    chk("power", {12'h000, o_div_power}, 16'h000F);
    chk("lines", {4'h0, lp & 12'h100}, 16'h0000);
    chk("lines_n", {4'h0, ln & 12'h020}, 16'h0000);
    rd(`ODSC_OUT_BASE + 16'h0002, 8'h0C);
    $display("[test] modes done");
    // Sync before lock stays pending
    sync_pulse();
    idle(8);
    chk("pending", {15'h0, o_div_hold}, 16'h0001);
    chk("held_pins", {4'h0, o_out_pos_pin}, 16'h0000);
    rd(`ODSC_STATUS_ADDR, 8'h0C);
    @(posedge i_clk);
    i_lock <= 1'b1;
    i_cal_done <= 1'b1;
    idle(6);
    chk("release", {15'h0, o_div_hold}, 16'h0000);
    rd(`ODSC_STATUS_ADDR, 8'h03);
    sync_pulse();
    idle(3);
    chk("locked", {15'h0, o_div_hold}, 16'h0000);
    $display("[test] sync done");
    // Polarity against a same-group reference with normal sense
    for (int p = 0; p < 4; p++)
    begin
      wr(`ODSC_OUT_BASE + 16'h0003, {3'h0, p[1:0], 3'h4});
      wr(`ODSC_UPDATE_ADDR, 8'h01);
      idle(3);
      chk("pol_p", {15'h0, o_out_pos_pin[3]}, {15'h0, {o_out_pos_pin[2] ^ p[1]}});
      chk("pol_n", {15'h0, o_out_neg_pin[3]}, {15'h0, {o_out_pos_pin[2] ^ ~p[0]}});
    end
    wr(`ODSC_OUT_BASE, 8'h00);
    wr(`ODSC_UPDATE_ADDR, 8'h01);
    idle(3);
    chk("power", {12'h000, o_div_power}, 16'h000E);
    $display("[test] polarity done");
    // Divide by four after a sync gives eight pin changes in sixteen cycles
    wr(`ODSC_DIV_BASE + 16'h0001, 8'h03);
    wr(`ODSC_UPDATE_ADDR, 8'h01);
    sync_pulse();
    idle(4);
    edges = 0;
    repeat (16)
    begin
      last = o_out_pos_pin;
      idle(1);
      if (o_out_pos_pin[2] !== last[2])
        edges++;
    end
    chk("toggles", edges[15:0], 16'h0008);
    $display("[test] divider done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
